// *** core/mote_core.sv ***
// op timing core: machine-cycle sequencer, decoder and external strobes
`timescale 1ns/10ps
module mote_core #(
   parameter int PROG_SIZE = mote_pkg::PROG_DEPTH
) (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   // device pins
   input  wire mote_pkg::mote_pins_in_t      pinIn,
   output mote_pkg::mote_pins_out_t          pinOut,
   // internal program store loading
   input  wire logic                         memLoadEn,
   input  wire logic [mote_pkg::PC_W-1:0]    memLoadAddr,
   input  wire logic [7:0]                   memLoadData
);
   import mote_pkg::*;

   localparam int              AW       = $clog2(PROG_SIZE);
   localparam logic [PC_W-1:0] PROG_TOP = PC_W'(PROG_SIZE);

   mote_state_t   st_r;
   mote_state_t   st_nxt;
   mote_pins_in_t sIn;
   mote_dec_t     dec;
   logic          tick;
   logic          startCyc;
   logic          addrPh;
   logic          strobePh;
   logic [7:0]    memData;
   logic [7:0]    fetched;
   logic [7:0]    operand;
   logic [8:0]    sum;

   assign sIn    = st_r.sync2;
   assign pinOut = st_r.pins;

   //****************************************************************
   // decoder: length, cycle count and strobe class
   //****************************************************************
   function automatic mote_dec_t decodeOp(input logic [7:0] op);
      mote_dec_t d;
      d.twoBytes = (op[7:4] <= OP_XOR && op[3:0] == IMM_SEL)
                   || op[7:4] == OP_PORT_MASK || op[7:4] == OP_BUS_MASK;
      d.twoCycles = d.twoBytes || op[7:4] inside {OP_PORT_READ,
                    OP_PORT_WRITE, OP_BUS_READ, OP_BUS_WRITE, OP_EXPANDER,
                    OP_EXT_DATA};
      d.io = IO_NONE;
      if (op[7:4] == OP_BUS_READ || (op[7:4] == OP_EXT_DATA && !op[1])) begin
         d.io = IO_LOAD;
      end else if (op[7:4] == OP_BUS_WRITE || op[7:4] == OP_EXT_DATA) begin
         d.io = IO_STORE;
      end else if (op[7:4] == OP_EXPANDER) begin
         d.io = IO_EXPAND;
      end
      return d;
   endfunction

   //****************************************************************
   // internal program store
   //****************************************************************
   mote_prog_mem #(
      .DEPTH (PROG_SIZE),
      .AW    (AW)
   ) progMem (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wrEn     (memLoadEn),
      .wrAddr   (memLoadAddr[AW-1:0]),
      .wrData   (memLoadData),
      .rdAddr   (st_r.pc[AW-1:0]),
      .rdData_r (memData)
   );

   //****************************************************************
   // next state
   //****************************************************************
   always_comb begin
      st_nxt   = st_r;
      dec      = decodeOp(st_r.ir);
      tick     = st_r.tickCnt == CLK_DIV - 2'h1;
      startCyc = 1'b0;
      sum      = 9'h000;
      fetched  = st_r.extFetch ? sIn.busIn : memData;
      operand  = st_r.regs[st_r.ir[2:0]];
      if (st_r.ir[3:0] == IMM_SEL) begin
         operand = st_r.data;
      end else if (st_r.ir[3]) begin
         operand = st_r.regs[st_r.regs[st_r.ir[0]][2:0]];
      end
      st_nxt.sync1   = pinIn;
      st_nxt.sync2   = st_r.sync1;
      st_nxt.tickCnt = tick ? 2'h0 : st_r.tickCnt + 2'h1;
      if (tick) begin
         unique case (st_r.phase)
            PH_ADDR:   st_nxt.phase = PH_LATCH;
            PH_LATCH:  st_nxt.phase = PH_STROBE;
            PH_STROBE: st_nxt.phase = PH_SAMPLE;
            PH_SAMPLE: begin
               st_nxt.phase = PH_END;
               if (st_r.fetchCycle) begin
                  st_nxt.pc = st_r.pc + PC_W'(1);
                  if (st_r.cycleNo) begin
                     st_nxt.data = fetched;
                  end else begin
                     st_nxt.ir = fetched; // RL15
                  end
               end else if (st_r.ioCls == IO_EXPAND) begin
                  st_nxt.data = {4'h0, sIn.p2In[3:0]};
               end else begin
                  st_nxt.data = sIn.busIn;
               end
            end
            PH_END: begin
               if (!st_r.cycleNo && dec.twoCycles) begin
                  st_nxt.cycleNo    = 1'b1; // RL9 RL11 RL12 RL13 RL18
                  st_nxt.fetchCycle = dec.twoBytes;
                  st_nxt.ioCls      = dec.io;
                  st_nxt.phase      = PH_ADDR;
                  startCyc          = 1'b1;
               end else begin
                  unique case (st_r.ir[7:4])
                     OP_SUM, OP_SUM_CARRY: begin // RL8 RL9
                        sum = {1'b0, st_r.acc} + {1'b0, operand}
                              + {8'h00, st_r.carry && st_r.ir[4]};
                        st_nxt.acc   = sum[7:0];
                        st_nxt.carry = sum[8];
                     end
                     OP_AND: st_nxt.acc = st_r.acc & operand;
                     OP_OR:  st_nxt.acc = st_r.acc | operand;
                     OP_XOR: st_nxt.acc = st_r.acc ^ operand;
                     OP_SINGLE: begin // RL10
                        unique case (st_r.ir[3:0])
                           SOP_PLUS_ONE:  st_nxt.acc = st_r.acc + 8'h01;
                           SOP_MINUS_ONE: st_nxt.acc = st_r.acc - 8'h01;
                           SOP_ZERO:      st_nxt.acc = 8'h00;
                           SOP_INVERT:    st_nxt.acc = ~st_r.acc;
                           SOP_BCD_FIXUP: begin
                              sum = {1'b0, st_r.acc};
                              if (sum[3:0] > 4'h9) begin
                                 sum = sum + 9'h006;
                              end
                              if (sum[8:4] > 5'h09 || st_r.carry) begin
                                 sum          = sum + 9'h060;
                                 st_nxt.carry = 1'b1;
                              end
                              st_nxt.acc = sum[7:0];
                           end
                           SOP_NIB_EXCH: st_nxt.acc = {st_r.acc[3:0], st_r.acc[7:4]};
                           SOP_ROT_LEFT: st_nxt.acc = {st_r.acc[6:0], st_r.acc[7]};
                           SOP_ROT_LEFT_C: {st_nxt.carry, st_nxt.acc} = {st_r.acc, st_r.carry};
                           SOP_ROT_RIGHT: st_nxt.acc = {st_r.acc[0], st_r.acc[7:1]};
                           SOP_ROT_RIGHT_C: {st_nxt.acc, st_nxt.carry} = {st_r.carry, st_r.acc};
                           default: ;
                        endcase
                     end
                     OP_PORT_READ: begin // RL11
                        st_nxt.acc = st_r.ir[0] ? sIn.p2In : sIn.p1In;
                     end
                     OP_PORT_WRITE: begin
                        if (st_r.ir[0]) begin
                           st_nxt.p2Latch = st_r.acc;
                        end else begin
                           st_nxt.p1Latch = st_r.acc;
                        end
                     end
                     OP_PORT_MASK: begin
                        if (st_r.ir[0]) begin
                           st_nxt.p2Latch = st_r.ir[1] ? st_r.p2Latch | st_r.data
                                                       : st_r.p2Latch & st_r.data;
                        end else begin
                           st_nxt.p1Latch = st_r.ir[1] ? st_r.p1Latch | st_r.data
                                                       : st_r.p1Latch & st_r.data;
                        end
                     end
                     OP_BUS_READ: st_nxt.acc = st_r.data; // RL12
                     OP_BUS_WRITE: begin
                        st_nxt.busLatch  = st_r.acc;
                        st_nxt.busDriven = 1'b1;
                     end
                     OP_BUS_MASK: begin
                        st_nxt.busLatch  = st_r.ir[1] ? st_r.busLatch | st_r.data
                                                      : st_r.busLatch & st_r.data;
                        st_nxt.busDriven = 1'b1;
                     end
                     OP_EXPANDER: begin // RL13
                        if (st_r.ir[3:2] == EXP_READ) begin
                           st_nxt.acc = st_r.data;
                        end
                     end
                     OP_EXT_DATA: begin
                        if (!st_r.ir[1]) begin
                           st_nxt.acc = st_r.data;
                        end
                     end
                     OP_INT_CTRL:  st_nxt.intEn = st_r.ir[0];
                     OP_REG_STORE: st_nxt.regs[st_r.ir[2:0]] = st_r.acc;
                  endcase
                  st_nxt.cycleNo    = 1'b0;
                  st_nxt.fetchCycle = 1'b1;
                  st_nxt.ioCls      = IO_NONE;
                  if (st_nxt.intEn && !sIn.extIrq_n) begin // RL16
                     st_nxt.pc    = INT_VECTOR;
                     st_nxt.intEn = 1'b0;
                  end
                  if (sIn.stepRequest) begin // RL6
                     st_nxt.phase = PH_PAUSE;
                  end else begin
                     st_nxt.phase = PH_ADDR;
                     startCyc     = 1'b1;
                  end
               end
            end
            PH_PAUSE: begin
               if (!sIn.stepRequest) begin // RL6
                  st_nxt.phase = PH_ADDR;
                  startCyc     = 1'b1;
               end
            end
         endcase
      end
      if (startCyc) begin
         st_nxt.extFetch = sIn.forceExternalFetch || st_nxt.pc >= PROG_TOP; // RL7
         st_nxt.extCycle = (st_nxt.fetchCycle && st_nxt.extFetch)
                           || (st_nxt.ioCls != IO_NONE && st_nxt.ir[7:4] == OP_EXT_DATA);
         st_nxt.addrByte = st_nxt.fetchCycle ? st_nxt.pc[7:0]
                                             : st_nxt.regs[st_nxt.ir[0]];
      end

      // pins follow the next phase
      addrPh   = st_nxt.phase == PH_ADDR || st_nxt.phase == PH_LATCH;
      strobePh = st_nxt.phase == PH_STROBE || st_nxt.phase == PH_SAMPLE;
      st_nxt.pins.addressStrobe = st_nxt.phase == PH_ADDR; // RL3
      st_nxt.pins.programStoreStrobe_n =
         !(strobePh && st_nxt.fetchCycle && st_nxt.extFetch); // RL5
      st_nxt.pins.loadStrobe_n     = !(strobePh && st_nxt.ioCls == IO_LOAD); // RL17
      st_nxt.pins.storeStrobe_n    = !(strobePh && st_nxt.ioCls == IO_STORE); // RL2
      st_nxt.pins.expanderStrobe_n = !(strobePh && st_nxt.ioCls == IO_EXPAND);
      st_nxt.pins.busOe  = st_nxt.busDriven;
      st_nxt.pins.busOut = st_nxt.busLatch;
      if (addrPh && st_nxt.extCycle) begin // RL4 RL15
         st_nxt.pins.busOe  = 1'b1;
         st_nxt.pins.busOut = st_nxt.addrByte;
      end else if (strobePh && st_nxt.ioCls == IO_STORE) begin // RL2
         st_nxt.pins.busOe  = 1'b1;
         st_nxt.pins.busOut = st_nxt.acc;
      end else if (strobePh && (st_nxt.ioCls == IO_LOAD
                   || (st_nxt.fetchCycle && st_nxt.extFetch))) begin // RL15 RL17
         st_nxt.pins.busOe = 1'b0;
      end
      st_nxt.pins.p1Out = st_nxt.p1Latch;
      st_nxt.pins.p2Out = st_nxt.p2Latch;
      if (addrPh && st_nxt.fetchCycle && st_nxt.extFetch) begin
         st_nxt.pins.p2Out[3:0] = st_nxt.pc[11:8]; // RL14
      end
      if (st_nxt.ioCls == IO_EXPAND) begin // RL13
         if (addrPh) begin
            st_nxt.pins.p2Out[3:0] = st_nxt.ir[3:0];
         end else if (strobePh) begin
            st_nxt.pins.p2Out[3:0] = st_nxt.ir[3:2] == EXP_READ ? NIB_IDLE
                                                                 : st_nxt.acc[3:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= ST_RST; // RL1 RL16
      end else begin
         st_r <= st_nxt;
      end
   end

   //****************************************************************
   // checks
   //****************************************************************
   logic [7:0] aleGap;
   logic       sawPause;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aleGap   <= 8'h00;
         sawPause <= 1'b1;
      end else if (st_nxt.pins.addressStrobe && !st_r.pins.addressStrobe) begin
         aleGap   <= 8'h00;
         sawPause <= 1'b0;
      end else begin
         aleGap   <= aleGap + 8'h01;
         sawPause <= sawPause || st_r.phase == PH_PAUSE;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_reset_idle: assert property ($rose(rst_n) |-> // RL1 RL16
      st_r.phase == PH_PAUSE && st_r.pc == RESET_PC && !st_r.intEn)
      else $error("core not idle after reset");
   chk_store_pulse: assert property ($fell(pinOut.storeStrobe_n) |-> // RL2
      (!pinOut.storeStrobe_n && pinOut.busOe)[*6] ##1 pinOut.storeStrobe_n)
      else $error("store strobe wrong width or bus not driven");
   chk_ale_width: assert property ($rose(pinOut.addressStrobe) |-> // RL3
      pinOut.addressStrobe[*3] ##1 !pinOut.addressStrobe)
      else $error("address strobe width wrong");
   chk_ale_period: assert property ($rose(pinOut.addressStrobe) && !$past(sawPause) |-> // RL3
      $past(aleGap) == 8'(CYCLE_CLKS - 1))
      else $error("address strobe not once per machine cycle");
   chk_addr_setup: assert property ($fell(pinOut.addressStrobe) && st_r.extCycle |-> // RL4
      pinOut.busOe && $stable(pinOut.busOut))
      else $error("address not stable at strobe fall");
   chk_fetch_only: assert property (!pinOut.programStoreStrobe_n |-> // RL5
      st_r.fetchCycle && st_r.extFetch && !pinOut.busOe)
      else $error("program strobe outside external fetch");
   chk_step_hold: assert property (st_r.phase == PH_PAUSE && sIn.stepRequest |=> // RL6
      st_r.phase == PH_PAUSE)
      else $error("core left pause while step held");
   chk_force_ext: assert property ($rose(pinOut.addressStrobe) && st_r.fetchCycle // RL7
      && $past(sIn.forceExternalFetch) |-> st_r.extFetch)
      else $error("forced fetch went internal");
   chk_two_cycles: assert property (st_r.phase == PH_END && tick && !st_r.cycleNo // RL18
      && dec.twoCycles |=> st_r.cycleNo && st_r.fetchCycle == $past(dec.twoBytes))
      else $error("two-cycle instruction not given second cycle");
   chk_one_cycle: assert property (st_r.phase == PH_END && tick && !st_r.cycleNo // RL8 RL10
      && !dec.twoCycles |=> !st_r.cycleNo && st_r.fetchCycle)
      else $error("one-cycle instruction overran");
   chk_pc_nibble: assert property (st_r.phase == PH_LATCH && st_r.fetchCycle // RL14 RL15
      && st_r.extFetch |-> pinOut.p2Out[3:0] == st_r.pc[11:8]
      && pinOut.busOut == st_r.pc[7:0])
      else $error("fetch address not on pins");
   chk_load_float: assert property (!pinOut.loadStrobe_n |-> // RL17
      !pinOut.busOe && pinOut.storeStrobe_n)
      else $error("bus driven during load strobe");

   cov_ext_fetch:  cover property ($fell(pinOut.programStoreStrobe_n));
   cov_bus_write:  cover property ($fell(pinOut.storeStrobe_n));
   cov_step_run:   cover property (st_r.phase == PH_PAUSE ##1 st_r.phase == PH_ADDR);
   cov_int_taken:  cover property ($fell(st_r.intEn) && st_r.pc == INT_VECTOR);
endmodule

// *** core/mote_pkg.sv ***
// package: constants, types and state layout of the op timing core
//****************************************************************
// Overview of operation
// RL1: reset low puts core in initial state
// RL2: store strobe pulses on bus and data writes
// RL3: one address strobe pulse per machine cycle
// RL4: address valid before address strobe falls
// RL5: program strobe only on external fetches
// RL6: step request pauses between single instructions
// RL7: force input sends every fetch external
// RL8: operand sum/logic ops: one byte, one cycle
// RL9: immediate sum/logic ops: two bytes, two cycles
// RL10: single accumulator ops: one byte, one cycle
// RL11: port read/write two cycles, masks two bytes
// RL12: bus port read/write two cycles, masks two bytes
// RL13: expander ops: one byte, two cycles
// RL14: upper pc nibble on port two low half
// RL15: low pc byte on bus, read under strobe
// RL16: interrupt needs enable; reset disables it
// RL17: load strobe pulses on bus and data reads
// RL18: every instruction one or two machine cycles
//****************************************************************
package mote_pkg;

   //****************************************************************
   // sizes and timing
   //****************************************************************
   localparam int              PC_W       = 12;
   localparam int              NUM_REGS   = 8;
   localparam int              PROG_DEPTH = 1024;
   localparam int              PHASES     = 5;
   localparam logic [1:0]      CLK_DIV    = 2'h3;
   localparam int              CYCLE_CLKS = PHASES * int'(CLK_DIV);
   localparam logic [PC_W-1:0] RESET_PC   = 12'h000;
   localparam logic [PC_W-1:0] INT_VECTOR = 12'h010;
   localparam logic [7:0]      PORT_IDLE  = 8'hFF;
   localparam logic [3:0]      NIB_IDLE   = 4'hF;
   localparam logic [3:0]      IMM_SEL    = 4'hF;

   //****************************************************************
   // opcode groups, upper nibble
   //****************************************************************
   localparam logic [3:0] OP_SUM        = 4'h0;
   localparam logic [3:0] OP_SUM_CARRY  = 4'h1;
   localparam logic [3:0] OP_AND        = 4'h2;
   localparam logic [3:0] OP_OR         = 4'h3;
   localparam logic [3:0] OP_XOR        = 4'h4;
   localparam logic [3:0] OP_SINGLE     = 4'h5;
   localparam logic [3:0] OP_PORT_READ  = 4'h6;
   localparam logic [3:0] OP_PORT_WRITE = 4'h7;
   localparam logic [3:0] OP_PORT_MASK  = 4'h8;
   localparam logic [3:0] OP_BUS_READ   = 4'h9;
   localparam logic [3:0] OP_BUS_WRITE  = 4'hA;
   localparam logic [3:0] OP_BUS_MASK   = 4'hB;
   localparam logic [3:0] OP_EXPANDER   = 4'hC;
   localparam logic [3:0] OP_EXT_DATA   = 4'hD;
   localparam logic [3:0] OP_INT_CTRL   = 4'hE;
   localparam logic [3:0] OP_REG_STORE  = 4'hF;

   // single accumulator ops, low nibble
   localparam logic [3:0] SOP_PLUS_ONE   = 4'h0;
   localparam logic [3:0] SOP_MINUS_ONE  = 4'h1;
   localparam logic [3:0] SOP_ZERO       = 4'h2;
   localparam logic [3:0] SOP_INVERT     = 4'h3;
   localparam logic [3:0] SOP_BCD_FIXUP  = 4'h4;
   localparam logic [3:0] SOP_NIB_EXCH   = 4'h5;
   localparam logic [3:0] SOP_ROT_LEFT   = 4'h6;
   localparam logic [3:0] SOP_ROT_LEFT_C = 4'h7;
   localparam logic [3:0] SOP_ROT_RIGHT  = 4'h8;
   localparam logic [3:0] SOP_ROT_RIGHT_C = 4'h9;

   localparam logic [1:0] EXP_READ = 2'h0;

   //****************************************************************
   // types
   //****************************************************************
   typedef enum logic [2:0] {
      PH_ADDR, PH_LATCH, PH_STROBE, PH_SAMPLE, PH_END, PH_PAUSE
   } mote_phase_t;

   typedef enum logic [1:0] {IO_NONE, IO_LOAD, IO_STORE, IO_EXPAND} mote_io_t;

   typedef struct packed {
      logic     twoBytes;
      logic     twoCycles;
      mote_io_t io;
   } mote_dec_t;

   typedef struct packed {
      logic [7:0] busIn;
      logic [7:0] p1In;
      logic [7:0] p2In;
      logic       stepRequest;
      logic       forceExternalFetch;
      logic       extIrq_n;
   } mote_pins_in_t;

   typedef struct packed {
      logic       addressStrobe;
      logic       programStoreStrobe_n;
      logic       loadStrobe_n;
      logic       storeStrobe_n;
      logic       expanderStrobe_n;
      logic [7:0] busOut;
      logic       busOe;
      logic [7:0] p1Out;
      logic [7:0] p2Out;
   } mote_pins_out_t;

   typedef struct packed {
      mote_pins_in_t              sync1;
      mote_pins_in_t              sync2;
      mote_pins_out_t             pins;
      logic [1:0]                 tickCnt;
      mote_phase_t                phase;
      logic                       cycleNo;
      logic                       fetchCycle;
      logic                       extFetch;
      logic                       extCycle;
      mote_io_t                   ioCls;
      logic [7:0]                 addrByte;
      logic [7:0]                 ir;
      logic [7:0]                 data;
      logic [7:0]                 acc;
      logic                       carry;
      logic                       intEn;
      logic                       busDriven;
      logic [PC_W-1:0]            pc;
      logic [NUM_REGS-1:0][7:0]   regs;
      logic [7:0]                 p1Latch;
      logic [7:0]                 p2Latch;
      logic [7:0]                 busLatch;
   } mote_state_t;

   //****************************************************************
   // reset values
   //****************************************************************
   localparam mote_pins_in_t PINS_IN_RST = '{extIrq_n: 1'b1, default: '0};
   localparam mote_pins_out_t PINS_OUT_RST = '{
      programStoreStrobe_n: 1'b1, loadStrobe_n: 1'b1, storeStrobe_n: 1'b1,
      expanderStrobe_n: 1'b1, p1Out: PORT_IDLE, p2Out: PORT_IDLE, default: '0};
   localparam mote_state_t ST_RST = '{
      sync1: PINS_IN_RST, sync2: PINS_IN_RST, pins: PINS_OUT_RST,
      phase: PH_PAUSE, ioCls: IO_NONE, fetchCycle: 1'b1, pc: RESET_PC,
      p1Latch: PORT_IDLE, p2Latch: PORT_IDLE, default: '0};

endpackage

// *** core/mote_prog_mem.sv ***
// internal program store with registered read data
`timescale 1ns/10ps
module mote_prog_mem #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // load port
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [7:0]    wrData,
   // fetch port
   input  wire logic [AW-1:0] rdAddr,
   output logic [7:0]         rdData_r
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      if (!rst_n) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= mem[rdAddr];
      end
   end
endmodule

// *** tb/mote_ext_mem.sv ***
// external program memory model
`timescale 1ns/10ps
module mote_ext_mem (
   // clock and pins
   input  wire logic                     core_clk,
   input  wire mote_pkg::mote_pins_out_t pinOut,
   output logic [7:0]                    busIn
);
   import mote_pkg::*;
   logic [7:0]      mem [4096];
   logic [PC_W-1:0] addr;
   logic [7:0]      last = 8'h00;
   always @(negedge pinOut.addressStrobe) addr = {pinOut.p2Out[3:0], pinOut.busOut};
   // released bus toggles
   always @(posedge core_clk) last <= pinOut.programStoreStrobe_n ? ~last : mem[addr];
   assign busIn = pinOut.programStoreStrobe_n ? last : mem[addr];
endmodule

// *** tb/tb.sv ***
// testbench: op group timing against a queue model
`timescale 1ns/10ps
module tb;
   import mote_pkg::*;
   logic           core_clk = 0;
   logic           rst_n    = 0;
   logic [7:0]     busIn, p1 = 0, p2 = 0;
   logic           step = 0, forceExt = 1, extIrq_n = 1, ldEn = 0;
   logic [11:0]    ldAddr = 0;
   logic [7:0]     ldData = 0;
   logic [55:0]    dirProg = 56'h52_50F0_0070_E152;
   mote_pins_in_t  pinIn;
   mote_pins_out_t pinOut;
   logic [15:0]    expQ[$];
   logic           sawPs, sawLd, sawSt, sawEx, aleD, started;
   int             n_fail = 0, checked = 0, aleCnt = 0, ales;
   assign pinIn = '{busIn, p1, p2, step, forceExt, extIrq_n};
   mote_core mote_core_i (.core_clk, .rst_n, .pinIn, .pinOut, .memLoadEn(ldEn),
      .memLoadAddr(ldAddr), .memLoadData(ldData));
   mote_ext_mem mote_ext_mem_i (.core_clk, .pinOut, .busIn);
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   //****
   // per machine cycle monitor
   //****
   always @(posedge core_clk) begin
      aleD <= pinOut.addressStrobe;
      if (!rst_n) started <= 0;
      else if (pinOut.addressStrobe && !aleD) begin
         aleCnt <= aleCnt + 1;
         if (started && expQ.size() > 0) check("cycle", sawPs ? {4'h0, mote_ext_mem_i.addr} :
            {13'h0200, sawEx, sawSt, sawLd}, expQ.pop_front());
         started <= 1;
         {sawPs, sawLd, sawSt, sawEx} <= 4'h0;
      end else begin
         sawPs <= sawPs | !pinOut.programStoreStrobe_n;
         sawLd <= sawLd | !pinOut.loadStrobe_n;
         sawSt <= sawSt | !pinOut.storeStrobe_n;
         sawEx <= sawEx | !pinOut.expanderStrobe_n;
      end
   end
   always @(posedge core_clk) #1 {p1, p2} <= 16'($urandom);
   //****
   // main sequence
   //****
   initial begin
      int a;
      logic [7:0] op;
      a = 0;
      void'($urandom(82));
      for (int i = 0; i < 4096; i++) mote_ext_mem_i.mem[i] = 8'h00;
      for (int r = 0; r < 6; r++) for (int g = 0; g < 14; g++) begin
         if (g == 5) op = {4'h5, 4'($urandom % 10)};
         else if (g == 12) op = {4'hC, 2'($urandom), 2'b00};
         else if (g == 13) op = {4'hD, 4'($urandom % 4)};
         else op = {4'(g), (g < 5 && r < 2) ? 4'hF : 4'($urandom)};
         mote_ext_mem_i.mem[a] = op;
         expQ.push_back(16'(a));
         if (op[7:4] < 5 && op[3:0] == 4'hF || op[7:4] == 8 || op[7:4] == 11) begin
            a++;
            mote_ext_mem_i.mem[a] = 8'($urandom);
            expQ.push_back(16'(a));
         end else if (op[7:4] > 5) expQ.push_back((op[7:4] == 9 || op[7:4] == 13 && !op[1]) ?
            16'h1001 : (op[7:4] > 9 && op[7:4] != 12) ? 16'h1002 :
            op[7:4] == 12 ? 16'h1004 : 16'h1000);
         a++;
      end
      repeat (5) @(posedge core_clk);
      check("strobe in reset", 16'(pinOut.programStoreStrobe_n), 16'h1);
      #1 rst_n = 1;
      for (int w = 0; w < 5000 && expQ.size() > 0; w++) @(posedge core_clk);
      check("queue drained", 16'(expQ.size()), 16'h0);
      $display("test op timing done");
      @(posedge core_clk) #1 step = 1;
      repeat (60) @(posedge core_clk);
      ales = aleCnt;
      repeat (60) @(posedge core_clk);
      check("ale while paused", 16'(aleCnt - ales), 16'h0);
      #1 step = 0;
      repeat (3) @(posedge core_clk);
      #1 step = 1;
      repeat (60) @(posedge core_clk);
      check("ale after step", 16'(aleCnt - ales), 16'h0001);
      $display("test single step done");
      // internal run: load store in reset, irq held low, force off
      @(posedge core_clk) #1 {rst_n, step, forceExt, extIrq_n} = 4'h0;
      for (int i = 0; i < 65; i++) @(posedge core_clk) #1 {ldEn, ldAddr, ldData} =
         {i < 64, 12'(i), i == 16 ? 8'h71 : i < 7 ? dirProg[55 - 8 * i -: 8] : 8'h00};
      repeat (9) expQ.push_back(16'h1000);
      @(posedge core_clk) #1 rst_n = 1;
      repeat (300) @(posedge core_clk);
      check("port one", 16'(pinOut.p1Out), 16'h0002);
      check("port two", 16'(pinOut.p2Out), 16'h0002);
      check("internal queue", 16'(expQ.size()), 16'h0000);
      $display("test internal run done");
      give_verdict();
   end
endmodule
